// [core/usart_codec_pkg.sv]
package usart_codec_pkg;
   // register byte offsets
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] mode_off = 8'h04;
   localparam logic [7:0] stat_off = 8'h14;
   localparam logic [7:0] rxh_off = 8'h18;
   localparam logic [7:0] txh_off = 8'h1C;
   localparam logic [7:0] brg_off = 8'h20;
   localparam logic [7:0] man_off = 8'h50;
   // control register bits (write only, self clearing)
   localparam int cr_status_reset_cmd = 8;
   localparam int cr_txen = 6;
   localparam int cr_txdis = 7;
   localparam int cr_rxen = 4;
   localparam int cr_rxdis = 5;
   // mode register fields
   localparam int mr_char_length_field_lo = 6;
   localparam int mr_sync = 8;
   localparam int mr_par_lo = 9;
   localparam int mr_stop_bit_count_lo = 12;
   localparam int mr_bit_order_select = 16;
   localparam int mr_nine_bit_select = 17;
   localparam int mr_over = 19;
   localparam int mr_sync_type_select = 29;
   localparam int mr_man = 18;
   localparam int mr_single_bit_delimiter = 31;
   localparam int mr_varsync = 30;
   // manchester config fields
   localparam int mc_txpl_lo = 0;
   localparam int mc_txpp_lo = 8;
   localparam int mc_txmpol = 12;
   localparam int mc_rxpl_lo = 16;
   localparam int mc_rxpp_lo = 24;
   localparam int mc_rxmpol = 28;
   localparam int mc_drift = 30;
   localparam int mc_manen = 31;
   // status bits
   localparam int sr_rxrdy = 0;
   localparam int sr_tx_ready_flag = 1;
   localparam int sr_pare = 7;
   localparam int sr_tx_empty_flag = 9;
   localparam int sr_code_violation_flag = 24;
   // reset values
   localparam logic [31:0] mode_rst = 32'h0000_00C0;
   localparam logic [31:0] man_rst = 32'h0000_0000;
   localparam logic [15:0] brg_rst = 16'h0001;
   // timing counts in oversampling ticks
   localparam logic [4:0] os16_bit = 5'h10;
   localparam logic [4:0] os8_bit = 5'h08;
   localparam logic [3:0] start16 = 4'h8;
   localparam logic [3:0] start8 = 4'h4;
   // axi responses
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// [core/line_sync_if.sv]
`timescale 1ns/1ps
interface line_sync_if;
   logic raw;
   logic clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// [core/line_sync.sv]
`timescale 1ns/1ps
module line_sync (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // line
   line_sync_if.sync ln
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic clean_q;
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         clean_q <= 1'b1;
      end else if (ce_i) begin
         s1_q <= ln.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            clean_q <= s3_q;
         end
      end
   end
   assign ln.clean = clean_q;
endmodule

// [core/usart_codec.sv]
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module usart_codec
   import usart_codec_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // axi4-lite slave
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [7:0] s_awaddr,
   input wire logic s_wvalid,
   output logic s_wready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   output logic s_bvalid,
   input wire logic s_bready,
   output logic [1:0] s_bresp,
   input wire logic s_arvalid,
   output logic s_arready,
   input wire logic [7:0] s_araddr,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   // serial line
   input wire logic rxd_i,
   output logic txd_o
);
   typedef enum logic [4:0] {
      tx_idle = 5'h01, tx_pre = 5'h02, tx_sfd = 5'h04,
      tx_data = 5'h08, tx_stop = 5'h10
   } tx_state_e;
   typedef enum logic [3:0] {
      rx_hunt = 4'h1, rx_start = 4'h2, rx_bits = 4'h4, rx_sfd = 4'h8
   } rx_state_e;

   logic [31:0] mode_register_q;
   logic [31:0] manchester_config_register_q;
   logic [15:0] brg_q;
   logic tx_en_q;
   logic rx_en_q;
   // bus
   logic aw_q;
   logic w_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   wire do_wr = aw_q && w_q && !bvalid_q;
   wire wr_mode = do_wr && awaddr_q == mode_off;
   wire wr_man = do_wr && awaddr_q == man_off;
   wire wr_brg = do_wr && awaddr_q == brg_off;
   wire wr_ctrl = do_wr && awaddr_q == ctrl_off;
   wire wr_thr = do_wr && awaddr_q == txh_off;
   wire wr_ok = wr_mode | wr_man | wr_brg | wr_ctrl | wr_thr;
   wire rd_go = s_arvalid && !rvalid_q;
   wire rd_rhr = rd_go && s_araddr == rxh_off;
   // configuration
   wire man_en = mode_register_q[mr_man];
   wire async_m = !mode_register_q[mr_sync];
   wire over8 = mode_register_q[mr_over];
   wire bit_order_select = mode_register_q[mr_bit_order_select];
   wire single_bit_delimiter = mode_register_q[mr_single_bit_delimiter];
   wire [3:0] nbits = mode_register_q[mr_nine_bit_select] ? 4'h9 :
      4'h5 + {2'h0, mode_register_q[mr_char_length_field_lo +: 2]};
   wire [2:0] par = mode_register_q[mr_par_lo +: 3];
   wire [1:0] stop_bit_count = mode_register_q[mr_stop_bit_count_lo +: 2];
   wire [3:0] txpl = manchester_config_register_q[mc_txpl_lo +: 4];
   wire [1:0] txpp = manchester_config_register_q[mc_txpp_lo +: 2];
   wire txpol = manchester_config_register_q[mc_txmpol];
   wire [3:0] rxpl = manchester_config_register_q[mc_rxpl_lo +: 4];
   wire [1:0] rxpp = manchester_config_register_q[mc_rxpp_lo +: 2];
   wire rxpol = manchester_config_register_q[mc_rxmpol];
   wire drift_en = manchester_config_register_q[mc_drift];
   // oversampling tick
   logic [15:0] div_q;
   wire tick = div_q == 16'h0000;
   wire [4:0] bit_len = over8 ? os8_bit : os16_bit;

   // transmitter
   tx_state_e tx_st_q;
   logic [9:0] thr_q;
   logic thr_full_q;
   logic [8:0] sh_q;
   logic sh_sync_q;
   logic parity_q;
   logic [3:0] tcnt_q;
   logic [5:0] tph_q;
   logic txd_q;
   logic tx_ready_flag_q;
   logic tx_empty_flag_q;
   wire [5:0] half = {2'h0, bit_len[4:1]};
   wire [5:0] tbit = {1'b0, bit_len};
   wire [5:0] stop_len = (stop_bit_count == 2'h1 && async_m) ?
      tbit + half : (stop_bit_count == 2'h2 ? tbit + tbit : tbit);
   wire tx_last_ph = tick && tph_q == tbit - 6'h01;
   wire [3:0] dbits = nbits + {3'h0, par != 3'h4};
   wire [3:0] didx = bit_order_select ? nbits - 4'h1 - tcnt_q : tcnt_q;
   wire par_bit = (par == 3'h0) ? ^sh_q : (par == 3'h1) ? ~^sh_q :
      (par == 3'h3);
   wire cur_bit = (tcnt_q == nbits) ? par_bit : sh_q[didx];
   wire first_half = tph_q < half;
   wire [1:0] pre_pat = txpp;
   wire pre_bit = pre_pat == 2'h0 ? 1'b1 : pre_pat == 2'h1 ? 1'b0 :
      (pre_pat == 2'h2 ? ~tcnt_q[0] : tcnt_q[0]);
   wire man_enc = (first_half ^ ~cur_bit) ^ txpol;
   wire pre_enc = (first_half ^ ~pre_bit) ^ txpol;
   wire sync_lvl = (tcnt_q == 4'h0 || (tcnt_q == 4'h1 && first_half))
      ^ ~sh_sync_q;
   wire [3:0] sfd_done = single_bit_delimiter ? 4'h0 : 4'h2;
   wire [9:0] nxt_chr = thr_q;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         div_q <= 16'h0000;
      end else if (ce_i) begin
         div_q <= tick ? brg_q - 16'h0001 : div_q - 16'h0001;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         tx_st_q <= tx_idle;
         thr_q <= 10'h000;
         thr_full_q <= 1'b0;
         sh_q <= 9'h000;
         sh_sync_q <= 1'b0;
         tcnt_q <= 4'h0;
         tph_q <= 6'h00;
         txd_q <= 1'b1;
      end else if (ce_i) begin
         if (wr_thr && tx_ready_flag_q) begin
            thr_q <= wdata_q[9:0];
            thr_full_q <= 1'b1;
         end
         if (tick) begin
            tph_q <= tph_q + 6'h01;
         end
         case (tx_st_q)
            tx_idle: begin
               txd_q <= 1'b1;
               if (tx_en_q && thr_full_q && tick) begin
                  sh_q <= nxt_chr[8:0];
                  sh_sync_q <= mode_register_q[mr_varsync] ? nxt_chr[9]
                     : mode_register_q[mr_sync_type_select];
                  thr_full_q <= 1'b0;
                  tph_q <= 6'h00;
                  tcnt_q <= 4'h0;
                  tx_st_q <= (man_en && txpl != 4'h0) ? tx_pre : tx_sfd;
               end
            end
            tx_pre: begin
               txd_q <= pre_enc;
               if (tx_last_ph) begin
                  tph_q <= 6'h00;
                  tcnt_q <= tcnt_q + 4'h1;
                  if (tcnt_q == txpl - 4'h1) begin
                     tcnt_q <= 4'h0;
                     tx_st_q <= tx_sfd;
                  end
               end
            end
            tx_sfd: begin
               if (!man_en) begin
                  txd_q <= 1'b0;
               end else if (single_bit_delimiter) begin
                  txd_q <= ~first_half ^ txpol;
               end else begin
                  txd_q <= sync_lvl ^ txpol;
               end
               if (tx_last_ph) begin
                  tph_q <= 6'h00;
                  tcnt_q <= tcnt_q + 4'h1;
                  if (!man_en || tcnt_q == sfd_done) begin
                     tcnt_q <= 4'h0;
                     tx_st_q <= tx_data;
                  end
               end
            end
            tx_data: begin
               txd_q <= man_en ? man_enc : cur_bit;
               if (tx_last_ph) begin
                  tph_q <= 6'h00;
                  tcnt_q <= tcnt_q + 4'h1;
                  if (tcnt_q == dbits - 4'h1) begin
                     tx_st_q <= tx_stop;
                  end
               end
            end
            tx_stop: begin
               txd_q <= 1'b1;
               if (tick && tph_q == stop_len - 6'h01) begin
                  tx_st_q <= tx_idle;
               end
            end
            default: tx_st_q <= tx_idle;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         tx_ready_flag_q <= 1'b0;
         tx_empty_flag_q <= 1'b0;
      end else if (ce_i) begin
         tx_ready_flag_q <= tx_en_q && !thr_full_q
            && !(wr_thr && tx_ready_flag_q);
         tx_empty_flag_q <= tx_en_q && !thr_full_q
            && tx_st_q == tx_idle && !wr_thr;
      end
   end

   // receiver
   line_sync_if rx_ln ();
   assign rx_ln.raw = rxd_i;
   line_sync u_rx_sync (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .ln(rx_ln)
   );
   wire rxd = rx_ln.clean ^ (man_en & rxpol);
   rx_state_e rx_st_q;
   logic [5:0] rph_q;
   logic [5:0] rlen_q;
   logic [3:0] rcnt_q;
   logic [9:0] rsh_q;
   logic [15:0] pre_sh_q;
   logic first_q;
   logic prev_q;
   logic rx_rdy_q;
   logic [9:0] rx_holding_register_q;
   logic code_violation_flag_q;
   logic pare_q;
   wire [5:0] rbit = {1'b0, bit_len};
   wire [5:0] rq1 = {3'h0, bit_len[4:2]};
   wire [5:0] rq3 = rq1 + rq1 + rq1;
   wire [3:0] st_need = over8 ? start8 : start16;
   wire [3:0] rdb = nbits + {3'h0, par != 3'h4};
   // async count 0 is the rest of the start bit, so data starts at 1
   wire [3:0] rpos = man_en ? rcnt_q : rcnt_q - 4'h1;
   wire [3:0] ridx = bit_order_select ? nbits - 4'h1 - rpos : rpos;
   wire rkeep = rpos < nbits;
   wire edge_seen = rxd != prev_q;
   wire drift_on = man_en && drift_en && !over8;
   wire early = drift_on && edge_seen && rph_q >= rbit - 6'h04
      && rph_q <= rbit - 6'h02;
   wire late = drift_on && edge_seen && rph_q >= 6'h02
      && rph_q <= 6'h03;
   wire rbit_end = tick && rph_q >= rlen_q - 6'h01;
   wire [1:0] pre_exp = rxpp;
   wire pre_ok = rxpl == 4'h0 || pre_exp[1] ||
      pre_sh_q[3:0] == (pre_exp[0] ? 4'h0 : 4'hF);
   wire sync_cmd = first_q;
   logic half1_q;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         rx_st_q <= rx_hunt;
         rph_q <= 6'h00;
         rlen_q <= 6'h10;
         rcnt_q <= 4'h0;
         rsh_q <= 10'h000;
         pre_sh_q <= 16'h0000;
         first_q <= 1'b0;
         prev_q <= 1'b1;
         half1_q <= 1'b0;
         rx_rdy_q <= 1'b0;
         rx_holding_register_q <= 10'h000;
         code_violation_flag_q <= 1'b0;
         pare_q <= 1'b0;
      end else if (ce_i) begin
         if (rd_rhr) begin
            rx_rdy_q <= 1'b0;
         end
         if (wr_ctrl && wdata_q[cr_status_reset_cmd]) begin
            code_violation_flag_q <= 1'b0;
            pare_q <= 1'b0;
         end
         if (tick) begin
            prev_q <= rxd;
            rph_q <= rph_q + 6'h01;
            case (rx_st_q)
               rx_hunt: begin
                  rph_q <= 6'h00;
                  if (rx_en_q && !rxd) begin
                     rx_st_q <= rx_start;
                  end
               end
               rx_start: begin
                  if (rxd) begin
                     rx_st_q <= rx_hunt;
                  end else if (man_en ? rph_q == rq1 - 6'h02
                     : rph_q == {2'h0, st_need} - 6'h02) begin
                     rph_q <= man_en ? rq1 : {2'h0, st_need};
                     rlen_q <= rbit;
                     rcnt_q <= 4'h0;
                     rx_st_q <= man_en ? rx_sfd : rx_bits;
                     first_q <= 1'b0;
                  end
               end
               rx_sfd: begin
                  // sample at the quarter point, shift that sample in at the three-quarter point
                  if (rph_q == rq1) begin
                     half1_q <= rxd;
                  end
                  if (rph_q == rq3) begin
                     pre_sh_q <= {pre_sh_q[14:0], half1_q};
                     if (rcnt_q == 4'h0) begin
                        first_q <= half1_q;
                     end
                  end
                  if (rbit_end) begin
                     rph_q <= 6'h00;
                     rcnt_q <= rcnt_q + 4'h1;
                     if (single_bit_delimiter && half1_q == 1'b0 && rxd) begin
                        rcnt_q <= 4'h0;
                        rx_st_q <= pre_ok ? rx_bits : rx_hunt;
                     end else if (!single_bit_delimiter && rcnt_q == 4'h2) begin
                        rcnt_q <= 4'h0;
                        rx_st_q <= pre_ok ? rx_bits : rx_hunt;
                     end else if (rcnt_q == rxpl + 4'h3) begin
                        rx_st_q <= rx_hunt;
                     end
                  end
               end
               rx_bits: begin
                  if (early) begin
                     rlen_q <= rbit - 6'h01;
                  end else if (late) begin
                     rlen_q <= rbit + 6'h01;
                  end
                  if (rph_q == (man_en ? rq1 : half)) begin
                     half1_q <= rxd;
                     if (!man_en && rkeep) begin
                        rsh_q[ridx] <= rxd;
                     end
                  end
                  if (man_en && rph_q == rq3) begin
                     if (half1_q == rxd && rcnt_q < rdb) begin
                        code_violation_flag_q <= 1'b1;
                     end
                     if (rkeep) begin
                        rsh_q[ridx] <= half1_q;
                     end
                  end
                  if (rbit_end) begin
                     rph_q <= 6'h00;
                     rlen_q <= rbit;
                     rcnt_q <= rcnt_q + 4'h1;
                     if (rcnt_q == rdb) begin
                        rx_st_q <= rx_hunt;
                        rx_rdy_q <= 1'b1;
                        rx_holding_register_q <=
                           {single_bit_delimiter ? 1'b0 : sync_cmd, rsh_q[8:0]};
                     end
                  end
               end
               default: rx_st_q <= rx_hunt;
            endcase
         end
      end
   end

   // control, configuration and bus
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         mode_register_q <= mode_rst;
         manchester_config_register_q <= man_rst;
         brg_q <= brg_rst;
         tx_en_q <= 1'b0;
         rx_en_q <= 1'b0;
      end else if (ce_i) begin
         if (wr_mode) begin
            mode_register_q <= wdata_q;
         end
         if (wr_man) begin
            manchester_config_register_q <= wdata_q;
         end
         if (wr_brg) begin
            brg_q <= (wdata_q[15:0] == 16'h0000) ? brg_rst : wdata_q[15:0];
         end
         if (wr_ctrl) begin
            if (wdata_q[cr_txdis]) begin
               tx_en_q <= 1'b0;
            end else if (wdata_q[cr_txen]) begin
               tx_en_q <= 1'b1;
            end
            if (wdata_q[cr_rxdis]) begin
               rx_en_q <= 1'b0;
            end else if (wdata_q[cr_rxen]) begin
               rx_en_q <= 1'b1;
            end
         end
      end
   end

   wire [31:0] stat_w = ({31'h0, rx_rdy_q} << sr_rxrdy)
      | ({31'h0, tx_ready_flag_q} << sr_tx_ready_flag)
      | ({31'h0, pare_q} << sr_pare)
      | ({31'h0, tx_empty_flag_q} << sr_tx_empty_flag)
      | ({31'h0, code_violation_flag_q} << sr_code_violation_flag);
   wire [31:0] rd_mux = (s_araddr == mode_off) ? mode_register_q :
      (s_araddr == man_off) ? manchester_config_register_q :
      (s_araddr == brg_off) ? {16'h0000, brg_q} :
      (s_araddr == stat_off) ? stat_w :
      (s_araddr == rxh_off) ? {22'h0, rx_holding_register_q} : 32'h0;
   wire rd_hit = s_araddr == mode_off || s_araddr == man_off ||
      s_araddr == brg_off || s_araddr == stat_off ||
      s_araddr == rxh_off;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         bvalid_q <= 1'b0;
         bresp_q <= resp_okay;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= resp_okay;
      end else if (ce_i) begin
         if (s_awvalid && !aw_q) begin
            aw_q <= 1'b1;
            awaddr_q <= s_awaddr;
         end
         if (s_wvalid && !w_q) begin
            w_q <= 1'b1;
            wdata_q <= s_wdata;
         end
         if (do_wr) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? resp_okay : resp_slverr;
         end
         if (bvalid_q && s_bready) begin
            bvalid_q <= 1'b0;
         end
         if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? resp_okay : resp_slverr;
         end
         if (rvalid_q && s_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign s_awready = !aw_q;
   assign s_wready = !w_q;
   assign s_bvalid = bvalid_q;
   assign s_bresp = bresp_q;
   assign s_arready = !rvalid_q;
   assign s_rvalid = rvalid_q;
   assign s_rdata = rdata_q;
   assign s_rresp = rresp_q;
   assign txd_o = txd_q;
endmodule

// [dv/usart_codec_properties.sv]
`timescale 1ns/1ps
module usart_codec_properties
   import usart_codec_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // bus
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic s_wvalid,
   input wire logic s_wready,
   input wire logic s_bvalid,
   input wire logic s_bready,
   input wire logic [1:0] s_bresp,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic [7:0] s_araddr,
   input wire logic s_rvalid,
   input wire logic s_rready,
   input wire logic [31:0] s_rdata,
   input wire logic [1:0] s_rresp,
   // line
   input wire logic txd_o
);
   logic [7:0] ra_q;
   wire stat_rd = s_rvalid && ra_q == stat_off;
   wire bad_rd = s_rvalid && !(ra_q inside
      {ctrl_off, mode_off, stat_off, rxh_off, txh_off, brg_off, man_off});
   always_ff @(posedge core_clk_i) begin
      if (s_arvalid && s_arready) ra_q <= s_araddr;
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   bresp_hold_a:
      assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write response dropped early");
   rdata_hold_a:
      assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read data dropped early");
   rd_answer_a:
      assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("read answer late");
   wr_answer_a:
      assert property (s_awvalid && s_awready && s_wvalid && s_wready
         |-> ##[1:2] s_bvalid)
      else $error("write answer late");
   bad_addr_a:
      assert property (bad_rd |-> s_rresp == resp_slverr)
      else $error("unmapped read not refused");
   empty_ready_a:
      assert property (stat_rd && s_rdata[sr_tx_empty_flag] |-> s_rdata[sr_tx_ready_flag])
      else $error("empty without ready");
   idle_high_a:
      assert property (disable iff (1'b0) !nrst_i ##1 !nrst_i |-> txd_o)
      else $error("line not idle in reset");
   start_len_a:
      assert property ($fell(txd_o) |=> !txd_o [*3])
      else $error("low level too short");
   cover property (s_bvalid && s_bready);
   cover property (stat_rd && s_rdata[sr_tx_empty_flag]);
   cover property ($fell(txd_o));
endmodule
bind usart_codec usart_codec_properties chk (.core_clk_i, .nrst_i,
   .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_bready,
   .s_bresp, .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready,
   .s_rdata, .s_rresp, .txd_o);

// [dv/line_partner.sv]
`timescale 1ns/1ps
module line_partner (
   // clock
   input wire logic core_clk_i,
   // line
   input wire logic line_i,
   output logic line_o
);
   logic [19:0] cap_q[$];
   logic [19:0] w;
   // half-bit samples of each frame from its falling edge
   initial begin
      line_o = 1'b1;
      forever begin
         @(negedge line_i);
         repeat (4) @(posedge core_clk_i);
         for (int k = 0; k < 20; k++) begin
            w[k] = line_i;
            if (k < 19) repeat (8) @(posedge core_clk_i);
         end
         cap_q.push_back(w);
      end
   end
   task automatic send(input logic [8:0] d, input int n, input int bt,
                       input logic msb);
      line_o <= 1'b0;
      repeat (bt) @(posedge core_clk_i);
      for (int k = 0; k < n; k++) begin
         line_o <= msb ? d[n-1-k] : d[k];
         repeat (bt) @(posedge core_clk_i);
      end
      line_o <= 1'b1;
      repeat (bt) @(posedge core_clk_i);
   endtask
   // coded frame as half-bit levels, eight clocks each
   task automatic send_halves(input logic [19:0] h);
      for (int k = 0; k < 20; k++) begin
         line_o <= h[k];
         repeat (8) @(posedge core_clk_i);
      end
      line_o <= 1'b1;
   endtask
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import usart_codec_pkg::*;
   logic core_clk_i = 0, nrst_i = 0, awv = 0, wv = 0, arv = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat;
   logic awr, wr, bv, arr, rv, txd, rxd;
   logic [1:0] bresp, rresp;
   int error_cnt = 0, checked = 0;
   int cn[4] = '{5, 8, 9, 9};
   logic cm[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   logic cx[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
   logic [8:0] cd[4] = '{9'h00B, 9'h0A6, 9'h1C3, 9'h0B1};
   usart_codec dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
      .s_awvalid(awv), .s_awready(awr), .s_awaddr(awa), .s_wvalid(wv),
      .s_wready(wr), .s_wdata(wd), .s_wstrb(4'hF), .s_bvalid(bv),
      .s_bready(1'b1), .s_bresp(bresp), .s_arvalid(arv), .s_arready(arr),
      .s_araddr(ara), .s_rvalid(rv), .s_rready(1'b1), .s_rdata(rdat),
      .s_rresp(rresp), .rxd_i(rxd), .txd_o(txd));
   line_partner partner (.core_clk_i(core_clk_i), .line_i(txd),
      .line_o(rxd));
   initial forever #25 core_clk_i = ~core_clk_i;
   task automatic chk(input string n, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      logic ad, dd;
      ad = 0;
      dd = 0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge core_clk_i);
         ad = ad | awr;
         dd = dd | wr;
         awv <= !ad;
         wv <= !dd;
      end
      do @(posedge core_clk_i); while (bv !== 1'b1);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      ara <= a;
      arv <= 1'b1;
      do @(posedge core_clk_i); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge core_clk_i); while (rv !== 1'b1);
      d = rdat;
      r = rresp;
   endtask
   function automatic logic [31:0] mode_w(input int n, input logic m, o, x);
      return (32'(n == 9 ? 3 : n - 5) << mr_char_length_field_lo) | (32'h4 << mr_par_lo)
         | (32'(m) << mr_bit_order_select) | (32'(n == 9) << mr_nine_bit_select)
         | (32'(o) << mr_over) | (32'(x) << mr_man) | (32'(x) << mr_single_bit_delimiter);
   endfunction
   // expected half-bit samples: start then data, coded or plain
   function automatic logic [19:0] halves(input logic [8:0] d, input int n,
                                          input logic msb, manchester_enable);
      logic [19:0] h;
      logic b;
      h = '1;
      for (int k = 0; k <= n; k++) begin
         b = k == 0 ? 1'b0 : (msb ? d[n-k] : d[k-1]);
         h[2*k] = b;
         h[2*k+1] = manchester_enable ? !b : b;
      end
      return h;
   endfunction
   task automatic wait_empty;
      logic [31:0] s;
      logic [1:0] r;
      s = '0;
      while (s[sr_tx_empty_flag] !== 1'b1) rd_reg(stat_off, s, r);
      chk("tx_ready_flag_at_empty", s[sr_tx_ready_flag], 1'b1);
      repeat (64) @(posedge core_clk_i);
   endtask
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic two;
      repeat (4) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      @(posedge core_clk_i);
      rd_reg(mode_off, d, r);
      chk("mode_rst", d, mode_rst);
      rd_reg(man_off, d, r);
      chk("man_rst", d, man_rst);
      rd_reg(brg_off, d, r);
      chk("brg_rst", d, 32'(brg_rst));
      rd_reg(8'hFC, d, r);
      chk("unmapped", r, resp_slverr);
      wr_reg(8'hFC, 32'h0);
      chk("unmapped_wr", bresp, resp_slverr);
      wr_reg(txh_off, 32'h55);
      rd_reg(stat_off, d, r);
      chk("flags_off", {d[sr_tx_empty_flag], d[sr_tx_ready_flag]}, 2'b00);
      wr_reg(ctrl_off, (32'h1 << cr_txen) | (32'h1 << cr_rxen));
      wait_empty();
      chk("lost_write", partner.cap_q.size(), 0);
      $display("status test done");
      for (int j = 0; j < 2; j++) begin
         d = j ? 32'h3C : 32'hC5;
         wr_reg(mode_off, mode_w(8, j, j, 0));
         partner.send(d[8:0], 8, j ? 8 : 16, j);
         repeat (8) @(posedge core_clk_i);
         rd_reg(stat_off, d, r);
         chk("rxrdy", d[sr_rxrdy], 1'b1);
         rd_reg(rxh_off, d, r);
         chk("rx_char", d[8:0], j ? 9'h03C : 9'h0C5);
         $display("rx test %0d done", j);
      end
      for (int i = 0; i < 4; i++) begin
         two = cn[i] > 5 && !cx[i];
         wr_reg(mode_off, mode_w(cn[i], cm[i], 0, cx[i]));
         wr_reg(man_off, 32'(cx[i]) << mc_manen);
         wr_reg(txh_off, 32'(cd[i]));
         if (two) begin
            wr_reg(txh_off, 32'(~cd[i]));
            wr_reg(txh_off, 32'h0);
         end
         wait_empty();
         chk("frames", partner.cap_q.size(), two ? 2 : 1);
         chk("frame", partner.cap_q[0],
            halves(cd[i], cn[i], cm[i], cx[i]));
         if (two) chk("frame2", partner.cap_q[1],
            halves(~cd[i], cn[i], cm[i], 0));
         partner.cap_q.delete();
         $display("tx test %0d done", i);
      end
      wr_reg(mode_off, mode_w(8, 0, 0, 1));
      wr_reg(man_off, 32'h0);
      for (int j = 0; j < 2; j++) begin
         partner.send_halves(halves(9'h0A5, 8, 0, 1) ^ 20'(j << 5));
         repeat (16) @(posedge core_clk_i);
         rd_reg(rxh_off, d, r);
         chk("man_char", d[9:0], 10'h0A5);
         rd_reg(stat_off, d, r);
         chk("code_err", d[sr_code_violation_flag], j[0]);
      end
      wr_reg(ctrl_off, 32'h1 << cr_status_reset_cmd);
      rd_reg(stat_off, d, r);
      chk("code_clr", d[sr_code_violation_flag], 1'b0);
      $display("manchester rx test done");
      wrap_up();
   end
   initial begin
      #3000000;
      error_cnt++;
      wrap_up();
   end
endmodule
